// *** iees_pkg.sv ***
package iees_pkg;
  // register map (byte addresses on the 32-bit apb)
  localparam logic [7:0] IEES_RLC_ADDR = 8'h00;
  localparam logic [7:0] IEES_PSW_ADDR = 8'h04;
  localparam logic [7:0] IEES_STAT_ADDR = 8'h08;
  localparam logic [7:0] IEES_FSAVE_ADDR = 8'h0c;
  localparam logic [7:0] IEES_FPC_ADDR = 8'h10;
  // resume_level_control fields
  localparam int IEES_RL_FAST_BIT = 3;
  localparam int IEES_RL_XFER_BIT = 5;
  localparam logic [7:0] IEES_RL_WMASK = 8'h2f;
  localparam logic [7:0] IEES_RL_RESET = 8'h20;
  // status word fields
  localparam int IEES_PSW_D_BIT = 1;
  localparam int IEES_PSW_I_BIT = 6;
  localparam int IEES_PSW_U_BIT = 7;
  localparam int IEES_PSW_THR_LSB = 12;
  localparam logic [15:0] IEES_PSW_RESET = 16'h0000;
  // information read addresses
  localparam logic [23:0] IEES_INFO_ADDR = 24'h000000;
  localparam logic [23:0] IEES_FAST_INFO_ADDR = 24'h000002;
  // sequence lengths in cpu cycles
  localparam logic [4:0] IEES_LEN_PERIPH_EVEN16 = 5'd14;
  localparam logic [4:0] IEES_LEN_PERIPH_OTHER = 5'd16;
  localparam logic [4:0] IEES_LEN_SPECIAL16 = 5'd13;
  localparam logic [4:0] IEES_LEN_SPECIAL8 = 5'd15;
  localparam logic [4:0] IEES_LEN_FAST = 5'd5;
  // instruction wait figure, level limits and source count
  localparam int IEES_DIV_WAIT = 40;
  localparam logic [2:0] IEES_LVL_MAX = 3'd7;
  localparam logic [2:0] IEES_LVL_RESET = 3'd0;
  localparam int IEES_NSRC = 8;

  typedef enum logic [2:0] {
    IEES_K_PERIPH, IEES_K_NMI, IEES_K_WDT, IEES_K_OSC,
    IEES_K_UNDEF, IEES_K_ADDR, IEES_K_SOFT, IEES_K_RESET
  } iees_kind_t;

  typedef struct packed {
    logic [23:0] pc;
    logic [15:0] psw;
  } iees_ctx_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } iees_push_t;
endpackage

// *** iees_top.sv ***
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - fast_level7_select set makes level 7 requests fast interrupts, else ordinary.
// - level7_transfer_select set makes level 7 start a channel transfer instead.
// - requests are judged after the current instruction ends; entry starts next cycle.
// - string and repeat multiply-accumulate instructions are suspended for entry.
// - read number and level at info address, fast address differs; clear pending flag.
// - copy old status word to a hidden temporary register.
// - then clear interrupt enable, single-step and stack-select flags.
// - write the temporary to the stack, or fast status save for fast entry.
// - save program counter to stack, or fast return pc save for fast entry.
// - stacked pc is 32 bits, upper half pushed first, after status word.
// - threshold takes the acknowledged peripheral level.
// - last step loads pc from the source vector.
// - watchdog, nmi, oscillation stop set 7; reset sets 0; traps leave it.
// - divide instruction wait is at most 40 cycles with register divisor.
// - memory divisor adds addressing dependent wait state cycles.
// - entry length 14 or 16 for peripheral, 13 or 15 for special sources.
// - fast entry completes in 5 cycles.
// - return_from_handler restores stacked status word and pc.
// - both returns switch the register bank back to the pre-entry bank.
// - maskable requests taken only above threshold; level 0 never taken.
// - among simultaneous requests only the highest priority is taken.
// - pending flags set by source requests, cleared on acknowledge.
module iees_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [iees_pkg::IEES_NSRC-1:0] src_req,
  input wire logic [iees_pkg::IEES_NSRC*3-1:0] source_priority_field,
  input wire logic [iees_pkg::IEES_NSRC*24-1:0] src_vector,
  input wire logic special_req,
  input wire iees_pkg::iees_kind_t special_kind,
  input wire logic [23:0] special_vector,
  input wire logic insn_done,
  input wire logic insn_suspendable,
  input wire logic bus_8bit,
  input wire logic [23:0] cur_pc,
  input wire logic cur_bank,
  input wire logic ret_normal,
  input wire logic ret_fast,
  input wire iees_pkg::iees_ctx_t stack_ctx,
  output iees_pkg::iees_push_t push_word,
  output logic [23:0] info_addr,
  output logic info_rd,
  output logic entry_busy,
  output logic pc_load,
  output logic [23:0] pc_value,
  output logic bank_load,
  output logic bank_value,
  output logic xfer_start,
  output logic [2:0] xfer_level,
  output logic [15:0] psw_out,
  output logic [2:0] threshold_out,
  output logic [iees_pkg::IEES_NSRC-1:0] pending_out
);
  import iees_pkg::*;

  typedef enum logic [1:0] {IEES_IDLE, IEES_RUN} iees_state_t;

  function automatic logic [2:0] lvl_of(input logic [IEES_NSRC*3-1:0] f, input int i);
    lvl_of = f[i*3 +: 3];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] rlc_q;
  logic [15:0] psw_q;
  logic [15:0] tmp_q;
  logic [15:0] fsave_q;
  logic [23:0] fpc_q;
  logic [IEES_NSRC-1:0] pend_q;
  logic saved_bank_q;
  iees_state_t st_q;
  logic [4:0] cnt_q;
  logic [4:0] len_q;
  logic fast_q;
  logic special_q;
  iees_kind_t kind_q;
  logic [2:0] lvl_q;
  logic [23:0] vec_q;
  logic [2:0] win_q;
  logic [IEES_NSRC-1:0] ack_q;
  logic [23:0] pc_save_q;
  logic info_rd_q;
  logic pc_load_q;
  logic [23:0] pc_value_q;
  logic bank_load_q;
  logic bank_value_q;
  logic xfer_q;
  iees_push_t push_q;
  logic [31:0] prdata_q;

  wire logic fast_sel = rlc_q[IEES_RL_FAST_BIT];
  wire logic xfer_sel = rlc_q[IEES_RL_XFER_BIT];
  wire logic [2:0] thr = psw_q[IEES_PSW_THR_LSB +: 3];
  wire logic i_flag = psw_q[IEES_PSW_I_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // priority select: higher level wins, lower index breaks ties
  logic [2:0] best_lvl [IEES_NSRC:0];
  logic [2:0] best_idx [IEES_NSRC:0];
  logic best_any [IEES_NSRC:0];
  assign best_lvl[0] = 3'h0;
  assign best_idx[0] = 3'h0;
  assign best_any[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < IEES_NSRC; g++)
    begin : g_sel
      wire logic cand = pend_q[g] && lvl_of(source_priority_field, g) > thr;
      wire logic better = cand && (!best_any[g] || lvl_of(source_priority_field, g) > best_lvl[g]);
      assign best_any[g+1] = best_any[g] | cand;
      assign best_lvl[g+1] = better ? lvl_of(source_priority_field, g) : best_lvl[g];
      assign best_idx[g+1] = better ? 3'(g) : best_idx[g];
    end
  endgenerate

  // long divides are waited out through insn_done
  wire logic sample_pt = insn_done | insn_suspendable;
  wire logic mask_ok = best_any[IEES_NSRC] && i_flag;
  wire logic lvl7 = best_lvl[IEES_NSRC] == IEES_LVL_MAX;
  // a transfer clears its flag one cycle late, so hold off the next decision
  wire logic idle_ok = st_q == IEES_IDLE && !xfer_q;
  wire logic go_xfer = idle_ok && sample_pt && !special_req && mask_ok
    && lvl7 && xfer_sel;
  wire logic go_entry = idle_ok && sample_pt && (special_req || (mask_ok && !go_xfer));
  wire logic go_fast = !special_req && lvl7 && fast_sel && !xfer_sel;
  wire logic [2:0] win_idx = best_idx[IEES_NSRC];
  wire logic [4:0] len_d = go_fast ? IEES_LEN_FAST
    : special_req ? (bus_8bit ? IEES_LEN_SPECIAL8 : IEES_LEN_SPECIAL16)
    : (bus_8bit || src_vector[win_idx*24]) ? IEES_LEN_PERIPH_OTHER
    : IEES_LEN_PERIPH_EVEN16;
  wire logic [IEES_NSRC-1:0] ack_d = (go_entry && !special_req) || go_xfer
    ? (IEES_NSRC'(1) << win_idx) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // entry step positions inside the counted sequence
  wire logic running = st_q == IEES_RUN;
  wire logic step_info = running && cnt_q == 5'd0;
  wire logic step_flag = running && cnt_q == 5'd1;
  wire logic step_psw = running && cnt_q == 5'd2;
  wire logic step_pchi = running && !fast_q && cnt_q == 5'd3;
  wire logic step_pclo = running && !fast_q && cnt_q == 5'd4;
  wire logic step_last = running && cnt_q == len_q - 5'd1;

  logic [2:0] thr_d;
  always_comb
  begin
    thr_d = thr;
    if (!special_q)
      thr_d = lvl_q;
    else if (kind_q == IEES_K_NMI || kind_q == IEES_K_WDT || kind_q == IEES_K_OSC)
      thr_d = IEES_LVL_MAX;
    else if (kind_q == IEES_K_RESET)
      thr_d = IEES_LVL_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  wire logic apb_wr = psel && penable && pwrite && pstrb[0];
  wire logic hit_rlc = paddr[7:0] == IEES_RLC_ADDR;
  wire logic hit_psw = paddr[7:0] == IEES_PSW_ADDR;
  wire logic hit_stat = paddr[7:0] == IEES_STAT_ADDR;
  wire logic hit_fs = paddr[7:0] == IEES_FSAVE_ADDR;
  wire logic hit_fpc = paddr[7:0] == IEES_FPC_ADDR;
  wire logic hit_any = paddr[31:8] == 24'h0 && (hit_rlc || hit_psw || hit_stat || hit_fs
    || hit_fpc);
  logic [31:0] rd_d;
  always_comb
  begin
    rd_d = 32'h0;
    if (hit_rlc)
      rd_d = {24'h0, rlc_q & IEES_RL_WMASK};
    else if (hit_psw)
      rd_d = {16'h0, psw_q};
    else if (hit_stat)
      rd_d = {16'h0, pend_q, 7'h0, running};
    else if (hit_fs)
      rd_d = {16'h0, fsave_q};
    else if (hit_fpc)
      rd_d = {8'h0, fpc_q};
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      prdata_q <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata_q <= hit_any ? rd_d : 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rlc_q <= IEES_RL_RESET; // transfer bit starts set, software must clear it
    else if (apb_wr && hit_rlc && hit_any)
      rlc_q <= pwdata[7:0] & IEES_RL_WMASK;
  end

  // source set wins over acknowledge clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pend_q <= '0;
    else
      pend_q <= (pend_q & ~(ack_q & {IEES_NSRC{step_info}}) & ~(xfer_q ? ack_q : '0))
        | src_req;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= IEES_IDLE;
      cnt_q <= 5'd0;
      len_q <= 5'd0;
      fast_q <= 1'b0;
      special_q <= 1'b0;
      kind_q <= IEES_K_PERIPH;
      lvl_q <= 3'h0;
      vec_q <= 24'h0;
      win_q <= 3'h0;
      ack_q <= '0;
      pc_save_q <= 24'h0;
      saved_bank_q <= 1'b0;
    end
    else if (go_entry)
    begin
      st_q <= IEES_RUN;
      cnt_q <= 5'd0;
      len_q <= len_d;
      fast_q <= go_fast;
      special_q <= special_req;
      kind_q <= special_kind;
      lvl_q <= best_lvl[IEES_NSRC];
      vec_q <= special_req ? special_vector : src_vector[win_idx*24 +: 24];
      win_q <= win_idx;
      ack_q <= ack_d;
      pc_save_q <= cur_pc;
      saved_bank_q <= cur_bank;
    end
    else if (go_xfer)
    begin
      ack_q <= ack_d;
      lvl_q <= best_lvl[IEES_NSRC];
    end
    else if (running)
    begin
      cnt_q <= cnt_q + 5'd1;
      if (step_last)
        st_q <= IEES_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      psw_q <= IEES_PSW_RESET;
      tmp_q <= 16'h0;
      fsave_q <= 16'h0;
      fpc_q <= 24'h0;
    end
    else
    begin
      if (step_info)
        tmp_q <= psw_q;
      if (step_flag)
      begin
        psw_q[IEES_PSW_I_BIT] <= 1'b0;
        psw_q[IEES_PSW_D_BIT] <= 1'b0;
        psw_q[IEES_PSW_U_BIT] <= 1'b0;
      end
      if (step_psw && fast_q)
        fsave_q <= tmp_q;
      if (step_psw && fast_q)
        fpc_q <= pc_save_q;
      if (step_last)
        psw_q[IEES_PSW_THR_LSB +: 3] <= thr_d;
      else if (!running && ret_normal)
        psw_q <= stack_ctx.psw;
      else if (!running && ret_fast)
        psw_q <= fsave_q;
      else if (!running && apb_wr && hit_psw && hit_any)
        psw_q <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  iees_push_t push_d;
  always_comb
  begin
    push_d = '0;
    if (step_psw && !fast_q)
      push_d = '{valid: 1'b1, data: tmp_q};
    else if (step_pchi)
      push_d = '{valid: 1'b1, data: {8'h0, pc_save_q[23:16]}};
    else if (step_pclo)
      push_d = '{valid: 1'b1, data: pc_save_q[15:0]};
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      push_q <= '0;
      info_rd_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_value_q <= 24'h0;
      bank_load_q <= 1'b0;
      bank_value_q <= 1'b0;
      xfer_q <= 1'b0;
    end
    else
    begin
      push_q <= push_d;
      info_rd_q <= go_entry;
      xfer_q <= go_xfer;
      pc_load_q <= step_last || (!running && (ret_normal || ret_fast));
      pc_value_q <= step_last ? vec_q : ret_fast ? fpc_q : stack_ctx.pc;
      bank_load_q <= !running && (ret_normal || ret_fast);
      bank_value_q <= saved_bank_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign push_word = push_q;
  assign info_rd = info_rd_q;
  assign info_addr = fast_q ? IEES_FAST_INFO_ADDR : IEES_INFO_ADDR;
  assign entry_busy = running;
  assign pc_load = pc_load_q;
  assign pc_value = pc_value_q;
  assign bank_load = bank_load_q;
  assign bank_value = bank_value_q;
  assign xfer_start = xfer_q;
  assign xfer_level = lvl_q;
  assign psw_out = psw_q;
  assign threshold_out = thr;
  assign pending_out = pend_q;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_fast_entry;
    go_entry && go_fast;
  endsequence

  a_fast_len5: assert property (@(posedge core_clk) disable iff (!resetn)
    s_fast_entry |=> running [*5] ##1 !running)
    else $error("fast entry length wrong");
  a_periph_len14: assert property (@(posedge core_clk) disable iff (!resetn)
    go_entry && !go_fast && !special_req && !bus_8bit && !src_vector[win_idx*24]
    |=> running [*7] ##1 running [*7] ##1 !running)
    else $error("peripheral entry length wrong");
  a_flags_cleared: assert property (@(posedge core_clk) disable iff (!resetn)
    step_flag |=> !psw_q[IEES_PSW_I_BIT] && !psw_q[IEES_PSW_D_BIT]
    && !psw_q[IEES_PSW_U_BIT])
    else $error("flags not cleared on entry");
  a_tmp_copy: assert property (@(posedge core_clk) disable iff (!resetn)
    step_info |=> tmp_q == $past(psw_q))
    else $error("status copy wrong");
  a_pc_order: assert property (@(posedge core_clk) disable iff (!resetn)
    step_pchi |=> push_q.data[7:0] == pc_save_q[23:16] ##1 push_q.data == pc_save_q[15:0])
    else $error("pc push order wrong");
  a_level_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    go_entry && !special_req |-> best_lvl[IEES_NSRC] > thr)
    else $error("request taken at or below threshold");
  a_xfer_lvl7: assert property (@(posedge core_clk) disable iff (!resetn)
    go_xfer |=> xfer_start && xfer_level == IEES_LVL_MAX && !running)
    else $error("level 7 transfer wrong");
  a_nmi_thr: assert property (@(posedge core_clk) disable iff (!resetn)
    step_last && special_q && kind_q == IEES_K_NMI |=> thr == IEES_LVL_MAX)
    else $error("special threshold wrong");
  a_vector_load: assert property (@(posedge core_clk) disable iff (!resetn)
    step_last |=> pc_load && pc_value == $past(vec_q))
    else $error("vector not loaded");
  a_ack_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    step_info && !special_q && !src_req[win_q] |=> !pend_q[win_q])
    else $error("pending flag not cleared");
endmodule
`default_nettype wire

// *** iees_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module iees_far_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic stall,
  input wire iees_pkg::iees_push_t push_word,
  input wire logic ret_normal,
  output logic insn_done,
  output iees_pkg::iees_ctx_t stack_ctx
);
  import iees_pkg::*;
  logic [15:0] stk[$];
  logic [1:0] ph_q;
  logic pop_q;
  // one instruction ends every fourth cycle; stall keeps a long one running
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ph_q <= 2'd0;
      insn_done <= 1'b0;
      pop_q <= 1'b0;
      stack_ctx <= '0;
      stk.delete();
    end
    else
    begin
      ph_q <= ph_q + 2'd1;
      insn_done <= (ph_q == 2'd3) && !stall;
      pop_q <= ret_normal;
      if (push_word.valid === 1'b1)
        stk.push_back(push_word.data);
      if (pop_q && stk.size() >= 3)
        repeat (3) void'(stk.pop_back());
      // an empty stack shows a changing pattern, never a stale frame
      if (stk.size() >= 3)
        stack_ctx <= {stk[stk.size()-2][7:0], stk[stk.size()-1], stk[stk.size()-3]};
      else
        stack_ctx <= ~stack_ctx;
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iees_pkg::*;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, er, stall, insn_done;
  logic special_req, insn_suspendable, bus_8bit, cur_bank, ret_normal, ret_fast, bk_m;
  logic info_rd, entry_busy, pc_load, bank_load, bank_value, xfer_start;
  logic [31:0] paddr, pwdata, prdata, rd, seed;
  logic [3:0] pstrb;
  logic [7:0] src_req, pending_out;
  logic [23:0] source_priority_field, special_vector, cur_pc, info_addr, pc_value;
  logic [191:0] src_vector;
  logic [2:0] xfer_level, threshold_out;
  logic [15:0] psw_out, psw_m;
  iees_kind_t special_kind;
  iees_ctx_t stack_ctx;
  iees_push_t push_word;
  logic [15:0] got[$];
  int err_count, samples_checked, n, b;

  iees_top iees_top_inst (.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req),
    .source_priority_field(source_priority_field), .src_vector(src_vector),
    .special_req(special_req), .special_kind(special_kind), .special_vector(special_vector),
    .insn_done(insn_done), .insn_suspendable(insn_suspendable), .bus_8bit(bus_8bit),
    .cur_pc(cur_pc), .cur_bank(cur_bank), .ret_normal(ret_normal), .ret_fast(ret_fast),
    .stack_ctx(stack_ctx), .push_word(push_word), .info_addr(info_addr), .info_rd(info_rd),
    .entry_busy(entry_busy), .pc_load(pc_load), .pc_value(pc_value), .bank_load(bank_load),
    .bank_value(bank_value), .xfer_start(xfer_start), .xfer_level(xfer_level),
    .psw_out(psw_out), .threshold_out(threshold_out), .pending_out(pending_out));

  iees_far_model iees_far_model_inst (.core_clk(core_clk), .resetn(resetn), .stall(stall),
    .push_word(push_word), .ret_normal(ret_normal), .insn_done(insn_done),
    .stack_ctx(stack_ctx));

  ////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // model of one entry: stacked frame, length, vector and new status word
  task automatic take(input int len, input logic [23:0] addr, input logic [23:0] vec,
    input logic [2:0] thr);
    int k;
    logic [15:0] w[$];
    k = 0;
    got.delete();
    w = '{psw_m, {8'h00, cur_pc[23:16]}, cur_pc[15:0]};
    if (addr != IEES_INFO_ADDR)
      w.delete();
    while (entry_busy !== 1'b1 && k < 300)
    begin
      @(posedge core_clk);
      k++;
    end
    special_req <= 1'b0;
    bk_m = cur_bank;
    check("info address", info_addr, addr);
    check("info read", info_rd, 1'b1);
    k = 0;
    while (entry_busy === 1'b1 && k < 40)
    begin
      @(posedge core_clk);
      k++;
    end
    if (len > 0) check("entry length", k, len);
    k = 0;
    while (pc_load !== 1'b1 && k < 5)
    begin
      @(posedge core_clk);
      k++;
    end
    check("pc load", pc_load, 1'b1);
    check("vector", pc_value, vec);
    psw_m = (psw_m & 16'h8f3d) | {1'b0, thr, 12'h000};
    check("status word", psw_out, psw_m);
    check("threshold", threshold_out, thr);
    if (len > 0) check("push count", got.size(), w.size());
    foreach (w[i])
      if (len > 0 && i < got.size()) check("pushed word", got[i], w[i]);
    cur_bank <= ~cur_bank;
  endtask

  task automatic ret(input logic f, input logic [23:0] pc, input logic [15:0] ps);
    int k;
    k = 0;
    ret_normal <= !f;
    ret_fast <= f;
    @(posedge core_clk);
    ret_normal <= 1'b0;
    ret_fast <= 1'b0;
    while (pc_load !== 1'b1 && k < 5)
    begin
      @(posedge core_clk);
      k++;
    end
    check("return load", pc_load, 1'b1);
    check("return pc", pc_value, pc);
    check("bank", {bank_load, bank_value}, {1'b1, bk_m});
    check("return status", psw_out, ps);
    psw_m = ps;
  endtask

  task automatic idle_check(input string what);
    b = 0;
    repeat (30)
    begin
      @(posedge core_clk);
      if (entry_busy === 1'b1) b++;
    end
    check(what, b, 0);
  endtask

  always @(posedge core_clk)
    if (push_word.valid === 1'b1) got.push_back(push_word.data);

  ////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // whole run is under 500 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end

  initial
  begin
    {psel, penable, pwrite, special_req, insn_suspendable, bus_8bit, cur_bank} = '0;
    {ret_normal, ret_fast, stall, src_req, paddr, pwdata, src_vector} = '0;
    {source_priority_field, special_vector, cur_pc, psw_m} = '0;
    pstrb = 4'hf;
    special_kind = IEES_K_NMI;
    resetn = 1'b0;
    seed = 32'h7fdf;
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, IEES_RLC_ADDR, 32'h0);
    check("resume level reset", rd, {24'h000000, IEES_RL_RESET});
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", er, 1'b1);
    apb(1'b1, IEES_RLC_ADDR, 32'h0);
    apb(1'b1, IEES_PSW_ADDR, 32'h00c2);
    apb(1'b0, IEES_PSW_ADDR, 32'h0);
    check("status readback", rd, 32'h00c2);
    psw_m = 16'h00c2;
    $display("test registers done");
    // src0 level 3 odd vector, src1 level 5, src2 level 0 never taken
    for (int i = 0; i < 8; i++)
    begin
      seed = nxt(seed);
      src_vector[24*i +: 24] <= {seed[23:1], i == 0}; // all but src0 even
    end
    cur_pc <= seed[31:8];
    source_priority_field <= 24'h00002b;
    src_req <= 8'h07;
    @(posedge core_clk);
    src_req <= 8'h00;
    @(posedge core_clk);
    check("pending", pending_out, 8'h07);
    take(14, IEES_INFO_ADDR, src_vector[47:24], 3'd5);
    check("pending after ack", pending_out, 8'h05);
    ret(1'b0, cur_pc, 16'h00c2);
    bus_8bit <= seed[0];
    take(16, IEES_INFO_ADDR, src_vector[23:0], 3'd3);
    ret(1'b0, cur_pc, 16'h00c2);
    apb(1'b1, IEES_PSW_ADDR, 32'h3040);
    src_req <= 8'h01;
    @(posedge core_clk);
    src_req <= 8'h00;
    idle_check("masked entry");
    apb(1'b1, IEES_PSW_ADDR, 32'h2040);
    psw_m = 16'h2040;
    take(16, IEES_INFO_ADDR, src_vector[23:0], 3'd3);
    ret(1'b0, cur_pc, 16'h2040);
    $display("test peripheral done");
    stall <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    special_vector <= 24'h000100;
    special_req <= 1'b1;
    idle_check("entry inside instruction");
    insn_suspendable <= 1'b1;
    take(bus_8bit ? 15 : 13, IEES_INFO_ADDR, 24'h000100, 3'd7);
    stall <= 1'b0;
    insn_suspendable <= 1'b0;
    for (int k = 1; k < 8; k++)
    begin
      if (k == 6) continue;
      seed = nxt(seed);
      bus_8bit <= seed[0];
      special_kind <= iees_kind_t'(k);
      special_vector <= {seed[23:1], 1'b0};
      cur_pc <= seed[31:8];
      special_req <= 1'b1;
      @(posedge core_clk);
      take((k == 3 || k == 7) ? -1 : (seed[0] ? 15 : 13), IEES_INFO_ADDR, special_vector,
        (k < 4) ? 3'd7 : ((k == 7) ? 3'd0 : psw_m[14:12]));
    end
    $display("test special done");
    apb(1'b1, IEES_RLC_ADDR, 32'h08);
    apb(1'b1, IEES_PSW_ADDR, 32'h0040);
    psw_m = 16'h0040;
    seed = nxt(seed);
    cur_pc <= seed[23:0];
    source_priority_field[11:9] <= 3'd7;
    src_req <= 8'h08;
    @(posedge core_clk);
    src_req <= 8'h00;
    take(5, IEES_FAST_INFO_ADDR, src_vector[95:72], 3'd7);
    apb(1'b0, IEES_FSAVE_ADDR, 32'h0);
    check("fast status save", rd, 32'h0040);
    apb(1'b0, IEES_FPC_ADDR, 32'h0);
    check("fast pc save", rd, {8'h00, cur_pc});
    ret(1'b1, cur_pc, 16'h0040);
    $display("test fast done");
    apb(1'b1, IEES_RLC_ADDR, 32'h20);
    apb(1'b1, IEES_PSW_ADDR, 32'h0040);
    src_req <= 8'h08;
    @(posedge core_clk);
    src_req <= 8'h00;
    n = 0;
    b = 0;
    while (xfer_start !== 1'b1 && n < 30)
    begin
      @(posedge core_clk);
      n++;
      if (entry_busy === 1'b1) b++;
    end
    check("transfer start", xfer_start, 1'b1);
    check("transfer level", xfer_level, 3'd7);
    check("no entry on transfer", b, 0);
    @(posedge core_clk);
    check("transfer pending", pending_out[3], 1'b0);
    $display("test transfer done");
    wrap_up();
  end
endmodule
`default_nettype wire
